// file: verilog/bus_fetch_event_counter.sv
// Qualifies bus, snoop, bus queue, fetch and translation events against the selected code.
// Assumes all observations are synchronous to clk_i; a counter elsewhere adds incr_o.
`include "bus_fetch_event_defs.svh"

module bus_fetch_event_counter
  import bus_fetch_event_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Event selection
  input  event_sel_t      sel_i,
  // Bus level observations
  input  bus_obs_t        bus_i,
  // Transaction completion and snoop responses
  input  bus_trans_t      trans_i,
  input  snoop_obs_t      snoop_i,
  // Fetch path observations
  input  fetch_obs_t      fetch_i,
  // Counter increment and selection status
  output logic            incr_o,
  output logic            supported_o
);

  qual_state_t            state;
  qual_state_t            next_state;
  logic [`EDGE_WIDTH-1:0] levels;
  logic [`EDGE_WIDTH-1:0] rises;

  logic                   is_burst_read;
  logic                   is_full_burst;
  logic                   is_partial;
  logic                   is_memory;
  logic                   fetch_counted;
  logic [2:0]             snoop_types;
  logic [1:0]             snoop_agent;
  logic                   snoop_type_hit;
  logic                   snoop_agent_hit;
  logic                   hit;
  logic                   known;

  assign levels[`EDGE_NOT_READY]   = bus_i.bus_not_ready_ind;
  assign levels[`EDGE_SNOOP_STALL] = bus_i.snoop_stall;

  level_rise_detect u_rise (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (levels),
    .rise_o  (rises)
  );

  // Transaction classes. Cacheable fetch-unit line reads are burst reads too.
  always_comb begin
    is_burst_read = trans_i.done &&
                    (trans_i.kind == TR_BURST_READ || trans_i.kind == TR_FETCH_LINE);
    is_full_burst = is_burst_read ||
                    (trans_i.done && (trans_i.kind == TR_READ_FOR_OWNERSHIP ||
                                      trans_i.kind == TR_EXPLICIT_WB ||
                                      trans_i.kind == TR_WC_FLUSH));
    is_partial    = trans_i.done &&
                    (trans_i.kind == TR_PARTIAL_READ || trans_i.kind == TR_PARTIAL_WRITE);
    // Memory is exactly the union of the three disjoint classes, so the sums agree.
    is_memory     = is_full_burst || is_partial ||
                    (trans_i.done && trans_i.kind == TR_INVALIDATE);
  end

  // Fetch events are per thread; the qualifier widens them to all threads.
  assign fetch_counted = fetch_i.this_thread | sel_i.all_threads_qualifier;

  // Snoop response filter from the unit mask.
  assign snoop_types = sel_i.umask[`UM_SNOOP_TYPE_HI:`UM_SNOOP_TYPE_LO];
  assign snoop_agent = sel_i.umask[`UM_SNOOP_AGENT_HI:`UM_SNOOP_AGENT_LO];

  always_comb begin
    snoop_type_hit  = 1'b0;
    snoop_agent_hit = 1'b0;
    unique case (snoop_i.resp)
      SNP_CLEAN:        snoop_type_hit = snoop_types[0];
      SNP_HIT:          snoop_type_hit = snoop_types[1];
      SNP_HIT_MODIFIED: snoop_type_hit = snoop_types[2];
      default:          snoop_type_hit = 1'b0;
    endcase
    if (snoop_agent == `UM_SNOOP_AGENT_ANY) begin
      snoop_agent_hit = 1'b1;
    end else if (snoop_agent == `UM_SNOOP_AGENT_OWN) begin
      snoop_agent_hit = snoop_i.own_agent;
    end
  end

  // Bus events ignore the thread qualifier: the bus is shared by every thread.
  always_comb begin
    hit   = 1'b0;
    known = 1'b1;
    case (sel_i.code)
      `EV_NOT_READY_DRIVEN: begin
        hit = rises[`EDGE_NOT_READY];
      end
      `EV_DATA_SEND_CYCLES: begin
        hit = bus_i.data_valid_ind & bus_i.data_write;
      end
      `EV_LOCK_CYCLES: begin
        hit = bus_i.lock;
      end
      `EV_DATA_RECEIVE_CYCLES: begin
        hit = bus_i.receiving;
      end
      `EV_BURST_READS: begin
        hit = is_burst_read;
      end
      `EV_OWNERSHIP_READS: begin
        hit = trans_i.done && trans_i.kind == TR_READ_FOR_OWNERSHIP;
      end
      `EV_EXPLICIT_WRITEBACKS: begin
        hit = trans_i.done && trans_i.kind == TR_EXPLICIT_WB;
      end
      `EV_FETCH_LINE_TRANSFERS: begin
        hit = trans_i.done && trans_i.kind == TR_FETCH_LINE;
      end
      `EV_INVALIDATES: begin
        hit = trans_i.done && trans_i.kind == TR_INVALIDATE;
      end
      `EV_PARTIAL_WRITES: begin
        hit = trans_i.done && trans_i.kind == TR_PARTIAL_WRITE;
      end
      `EV_PARTIAL_ALL: begin
        hit = is_partial;
      end
      `EV_PORT_IO: begin
        hit = trans_i.done && trans_i.kind == TR_PORT_IO;
      end
      `EV_DEFERRED: begin
        hit = trans_i.done && trans_i.kind == TR_DEFERRED;
      end
      `EV_FULL_LINE_BURSTS: begin
        hit = is_full_burst;
      end
      `EV_MEMORY_TRANSFERS: begin
        hit = is_memory;
      end
      `EV_ALL_TRANSFERS: begin
        hit = trans_i.done;
      end
      `EV_SNOOP_RESPONSES: begin
        known = (snoop_types != `UM_SNOOP_TYPE_NONE) &&
                (snoop_agent == `UM_SNOOP_AGENT_ANY ||
                 snoop_agent == `UM_SNOOP_AGENT_OWN);
        hit   = snoop_i.valid & snoop_type_hit & snoop_agent_hit;
      end
      `EV_SHARED_HIT_DRIVEN: begin
        hit = bus_i.snoop_hit_pin;
      end
      `EV_MODIFIED_HIT_DRIVEN: begin
        hit = bus_i.snoop_modified_pin;
      end
      `EV_QUEUE_IDLE: begin
        hit = bus_i.queue_empty;
      end
      `EV_SNOOP_STALL: begin
        hit = rises[`EDGE_SNOOP_STALL];
      end
      `EV_PORT_IO_WAIT: begin
        hit = bus_i.port_io_waiting;
      end
      `EV_FETCH: begin
        if (sel_i.umask == `UM_FETCH_ACCESSES) begin
          hit = fetch_i.access & fetch_counted;
        end else if (sel_i.umask == `UM_FETCH_MISSES) begin
          // The access pulse is one per fetch, so a miss counts once however long it waits.
          hit = fetch_i.access & (fetch_i.miss | fetch_i.mem_request) & fetch_counted;
        end else begin
          known = 1'b0;
        end
      end
      `EV_XLATE: begin
        if (sel_i.umask == `UM_XLATE_FLUSHES) begin
          hit = fetch_i.xlate_flush & fetch_counted;
        end else if (sel_i.umask == `UM_XLATE_MISSES) begin
          hit = fetch_i.xlate_miss & fetch_counted;
        end else begin
          known = 1'b0;
        end
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state           = state;
    next_state.supported = sel_i.enable & known;
    next_state.incr      = sel_i.enable & known & hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign incr_o      = state.incr;
  assign supported_o = state.supported;

endmodule : bus_fetch_event_counter

// file: common/bus_fetch_event_defs.svh
// Event codes, unit masks and field positions for the bus and fetch event qualifier.
// Assumes the includer compiles it once per unit; the guard prevents double definition.
// Notes on behaviour
// - 61H counts each not-ready assertion.
// - 62H counts data-valid cycles while writing.
// - 63H counts bus lock cycles.
// - 64H counts cycles receiving bus data.
// - 65H counts burst reads, not ownership reads.
// - 66H counts read-for-ownership transactions.
// - 67H counts explicit writebacks, not implicit.
// - 68H counts full-line fetch transfers.
// - 69H counts invalidate transactions.
// - 6AH partial writes; 6BH all partials.
// - 6CH counts completed port transactions.
// - 6EH counts full-line burst transactions.
// - 6FH equals burst plus partial plus invalidate.
// - 70H counts every bus transaction.
// - 77H snoop responses, filtered type and agent.
// - 7AH hit driven; 7BH modified hit.
// - 7DH counts bus queue idle cycles.
// - 7EH counts snoop-stall assertions.
// - 7FH counts cycles port requests wait.
// - 80H fetch accesses, misses counted once.
// - 82H translation flushes and misses.
// - Bus events shared, never split per thread.
`ifndef BUS_FETCH_EVENT_DEFS_SVH
`define BUS_FETCH_EVENT_DEFS_SVH

`define EV_NOT_READY_DRIVEN     8'h61
`define EV_DATA_SEND_CYCLES     8'h62
`define EV_LOCK_CYCLES          8'h63
`define EV_DATA_RECEIVE_CYCLES  8'h64
`define EV_BURST_READS          8'h65
`define EV_OWNERSHIP_READS      8'h66
`define EV_EXPLICIT_WRITEBACKS  8'h67
`define EV_FETCH_LINE_TRANSFERS 8'h68
`define EV_INVALIDATES          8'h69
`define EV_PARTIAL_WRITES       8'h6A
`define EV_PARTIAL_ALL          8'h6B
`define EV_PORT_IO              8'h6C
`define EV_DEFERRED             8'h6D
`define EV_FULL_LINE_BURSTS     8'h6E
`define EV_MEMORY_TRANSFERS     8'h6F
`define EV_ALL_TRANSFERS        8'h70
`define EV_SNOOP_RESPONSES      8'h77
`define EV_SHARED_HIT_DRIVEN    8'h7A
`define EV_MODIFIED_HIT_DRIVEN  8'h7B
`define EV_QUEUE_IDLE           8'h7D
`define EV_SNOOP_STALL          8'h7E
`define EV_PORT_IO_WAIT         8'h7F
`define EV_FETCH                8'h80
`define EV_XLATE                8'h82

`define UM_FETCH_ACCESSES       8'h03
`define UM_FETCH_MISSES         8'h02
`define UM_XLATE_FLUSHES        8'h04
`define UM_XLATE_MISSES         8'h02

// Snoop response unit mask: low three bits pick response types, top two the agent.
`define UM_SNOOP_TYPE_LO        0
`define UM_SNOOP_TYPE_HI        2
`define UM_SNOOP_AGENT_LO       6
`define UM_SNOOP_AGENT_HI       7
`define UM_SNOOP_AGENT_OWN      2'h1
`define UM_SNOOP_AGENT_ANY      2'h3
`define UM_SNOOP_TYPE_NONE      3'h0

`define EDGE_WIDTH              2
`define EDGE_NOT_READY          0
`define EDGE_SNOOP_STALL        1

`endif

// file: common/bus_fetch_event_pkg.sv
// Types shared by the bus and fetch event qualifier and its edge detector.
// Assumes all inputs are synchronous to the core clock.
package bus_fetch_event_pkg;

  // Kind of a bus transaction reported on a completion pulse.
  typedef enum logic [3:0] {
    TR_BURST_READ,
    TR_FETCH_LINE,
    TR_READ_FOR_OWNERSHIP,
    TR_EXPLICIT_WB,
    TR_IMPLICIT_WB,
    TR_INVALIDATE,
    TR_PARTIAL_READ,
    TR_PARTIAL_WRITE,
    TR_WC_FLUSH,
    TR_PORT_IO,
    TR_DEFERRED,
    TR_OTHER
  } trans_kind_t;

  typedef enum logic [1:0] {
    SNP_CLEAN,
    SNP_HIT,
    SNP_HIT_MODIFIED
  } snoop_resp_t;

  typedef struct packed {
    logic       enable;
    logic [7:0] code;
    logic [7:0] umask;
    logic       all_threads_qualifier;
  } event_sel_t;

  typedef struct packed {
    logic bus_not_ready_ind;
    logic data_valid_ind;
    logic data_write;
    logic lock;
    logic receiving;
    logic snoop_hit_pin;
    logic snoop_modified_pin;
    logic snoop_stall;
    logic queue_empty;
    logic port_io_waiting;
  } bus_obs_t;

  typedef struct packed {
    logic        done;
    trans_kind_t kind;
  } bus_trans_t;

  typedef struct packed {
    logic        valid;
    snoop_resp_t resp;
    logic        own_agent;
  } snoop_obs_t;

  typedef struct packed {
    logic access;
    logic miss;
    logic mem_request;
    logic this_thread;
    logic xlate_flush;
    logic xlate_miss;
  } fetch_obs_t;

  typedef struct packed {
    logic [1:0] prev;
  } edge_state_t;

  typedef struct packed {
    logic incr;
    logic supported;
  } qual_state_t;

endpackage : bus_fetch_event_pkg

// file: verilog/level_rise_detect.sv
// Turns level indications into one-cycle pulses on their rising edge.
// Assumes the levels are synchronous to clk_i; the pulse is combinational from the input.
`include "bus_fetch_event_defs.svh"

module level_rise_detect
  import bus_fetch_event_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Levels in, pulses out
  input  wire logic [`EDGE_WIDTH-1:0]   level_i,
  output logic      [`EDGE_WIDTH-1:0]   rise_o
);

  edge_state_t state;
  edge_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.prev = level_i;
  end

  // A level held through reset reads as a fresh assertion once reset releases.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise_o = level_i & ~state.prev;

endmodule : level_rise_detect

// file: bench/bus_fetch_event_props.sv
// Concurrent checks on the ports of the bus and fetch event qualifier.
// Assumes one clock domain with a synchronous active-high reset.
module bus_fetch_event_props
  import bus_fetch_event_pkg::*;
(
  // Clock and reset
  input wire logic  clk_i,
  input wire logic  rst_i,
  // Watched ports
  input event_sel_t sel_i,
  input bus_obs_t   bus_i,
  input bus_trans_t trans_i,
  input snoop_obs_t snoop_i,
  input fetch_obs_t fetch_i,
  input wire logic  incr_o,
  input wire logic  supported_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A disabled selection reads as code zero, which nothing counts.
  logic [7:0] c;
  assign c = sel_i.enable ? sel_i.code : 8'h00;
  sequence s_nr_rise;
    !bus_i.bus_not_ready_ind ##1 (bus_i.bus_not_ready_ind && c == 8'h61);
  endsequence
  sequence s_nr_held;
    bus_i.bus_not_ready_ind [*2] ##0 c == 8'h61;
  endsequence
  chk_nr_rise: assert property (s_nr_rise |=> incr_o) else $error("rise missed");
  chk_nr_held: assert property (s_nr_held |=> !incr_o) else $error("held level counted");
  chk_send_write: assert property (c == 8'h62 && bus_i.data_valid_ind && !bus_i.data_write |=> !incr_o)
    else $error("read data counted");
  chk_lock_level: assert property (c == 8'h63 && bus_i.lock |=> incr_o) else $error("lock missed");
  chk_implicit_wb: assert property (c == 8'h67 && trans_i.done && trans_i.kind == TR_IMPLICIT_WB |=> !incr_o)
    else $error("implicit writeback counted");
  chk_mem_partial: assert property (c == 8'h6F && trans_i.done && trans_i.kind == TR_PARTIAL_READ |=> incr_o)
    else $error("partial read missed");
  chk_snoop_agent: assert property (c == 8'h77 && sel_i.umask == 8'h47 && snoop_i.valid && !snoop_i.own_agent
    |=> !incr_o) else $error("foreign snoop counted");
  chk_queue_idle: assert property (c == 8'h7D && bus_i.queue_empty |=> incr_o) else $error("idle missed");
  chk_disabled: assert property (!sel_i.enable |=> !incr_o && !supported_o) else $error("disabled active");
  chk_fetch_mask: assert property (c == 8'h80 && !(sel_i.umask inside {8'h02, 8'h03})
    |=> !supported_o && !incr_o) else $error("bad mask accepted");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !incr_o && !supported_o)
    else $error("active in reset");
endmodule : bus_fetch_event_props

bind bus_fetch_event_counter bus_fetch_event_props u_bus_fetch_event_props (
  .clk_i       (clk_i),
  .rst_i       (rst_i),
  .sel_i       (sel_i),
  .bus_i       (bus_i),
  .trans_i     (trans_i),
  .snoop_i     (snoop_i),
  .fetch_i     (fetch_i),
  .incr_o      (incr_o),
  .supported_o (supported_o)
);

// file: bench/bus_agent_model.sv
// Model of the other bus agents: bus levels, transaction completions and snoop responses.
// Assumes callers enter its tasks just after a rising edge of clk_i.
module bus_agent_model
  import bus_fetch_event_pkg::*;
(
  input  wire logic  clk_i,
  output bus_obs_t   bus_o,
  output bus_trans_t trans_o,
  output snoop_obs_t snoop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_o = '0;
    trans_o = '0;
    snoop_o = '0;
  end
  task automatic hold(input bus_obs_t v);
    bus_o = v;
  endtask : hold
  // Released lines show the inverse so a stale kind is never mistaken for a fresh one.
  task automatic send_trans(input trans_kind_t k);
    while (bus_o.snoop_stall) begin
      @(posedge clk_i);
      #1;
    end
    trans_o = '{1'b1, k};
    @(posedge clk_i);
    #1;
    trans_o = '{1'b0, trans_kind_t'(~k)};
    @(posedge clk_i);
    #1;
  endtask : send_trans
  task automatic send_snoop(input snoop_resp_t r, input logic own);
    snoop_o = '{1'b1, r, own};
    @(posedge clk_i);
    #1;
    snoop_o = '{1'b0, snoop_resp_t'(~r), ~own};
    @(posedge clk_i);
    #1;
  endtask : send_snoop
endmodule : bus_agent_model

// file: bench/tb.sv
// Self-checking bench for the bus and fetch event qualifier.
// Assumes the package, the design, the checker and the bus agent model are compiled first.
module tb
  import bus_fetch_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i;
  event_sel_t sel_i;
  fetch_obs_t fetch_i;
  bus_obs_t   bus_i;
  bus_trans_t trans_i;
  snoop_obs_t snoop_i;
  logic       incr_o;
  logic       supported_o;
  int         num_errors = 0;
  int         compares = 0;
  int         hits = 0;
  always #12.5 clk_i = ~clk_i;
  // Pulses are counted mid-cycle so the count never races the registering edge.
  always @(negedge clk_i) if (incr_o === 1'b1) hits++;
  bus_fetch_event_counter u_bus_fetch_event_counter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sel_i       (sel_i),
    .bus_i       (bus_i),
    .trans_i     (trans_i),
    .snoop_i     (snoop_i),
    .fetch_i     (fetch_i),
    .incr_o      (incr_o),
    .supported_o (supported_o)
  );
  bus_agent_model u_bus_agent_model (.clk_i, .bus_o(bus_i), .trans_o(trans_i), .snoop_o(snoop_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pick(input logic [7:0] c, input logic [7:0] m, input logic s);
    sel_i = '{1'b1, c, m, 1'b0};
    tick(2);
    check(supported_o, s);
    hits = 0;
  endtask : pick
  task automatic fp(input logic [5:0] v);
    fetch_i = v;
    tick(1);
    fetch_i = '0;
    tick(1);
  endtask : fp
  task automatic t_levels;
    logic [7:0] lc [10] = '{8'h62, 8'h62, 8'h63, 8'h64, 8'h7A, 8'h7B, 8'h7D, 8'h7F, 8'h61, 8'h7E};
    logic [9:0] lv [10] = '{10'h180, 10'h100, 10'h40, 10'h20, 10'h10, 10'h8, 10'h2, 10'h1, 10'h200, 10'h4};
    int         le [10] = '{4, 0, 4, 4, 4, 4, 4, 4, 2, 2};
    for (int i = 0; i < 10; i++) begin
      // Bus events ignore the unit mask's middle bits and the thread qualifier alike.
      pick(lc[i], 8'h38, 1'b1);
      sel_i.all_threads_qualifier = i[0];
      u_bus_agent_model.hold(lv[i]);
      tick(3);
      u_bus_agent_model.hold('0);
      tick(1);
      u_bus_agent_model.hold(lv[i]);
      tick(1);
      u_bus_agent_model.hold('0);
      tick(2);
      check(hits, le[i]);
    end
  endtask : t_levels
  task automatic t_trans;
    logic [7:0]  tc [12] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70};
    logic [11:0] tm [12] = '{12'h3, 12'h4, 12'h8, 12'h2, 12'h20, 12'h80, 12'hC0, 12'h200, 12'h400, 12'h10F,
                             12'h1EF, 12'hFFF};
    for (int i = 0; i < 12; i++) begin
      pick(tc[i], 8'h00, 1'b1);
      for (int k = 0; k < 12; k++) begin
        hits = 0;
        u_bus_agent_model.send_trans(trans_kind_t'(k));
        check(hits, tm[i][k]);
      end
    end
  endtask : t_trans
  task automatic t_snoop;
    for (int t = 0; t < 3; t++) begin
      pick(8'h77, 8'hC0 | (8'h01 << t), 1'b1);
      for (int r = 0; r < 3; r++) u_bus_agent_model.send_snoop(snoop_resp_t'(r), 1'b0);
      check(hits, 1);
    end
    pick(8'h77, 8'h47, 1'b1);
    u_bus_agent_model.send_snoop(SNP_HIT, 1'b0);
    u_bus_agent_model.send_snoop(SNP_HIT, 1'b1);
    check(hits, 1);
    pick(8'h77, 8'hC0, 1'b0);
    pick(8'h77, 8'h87, 1'b0);
  endtask : t_snoop
  task automatic t_fetch;
    pick(8'h80, 8'h03, 1'b1);
    fp(6'h24);
    fp(6'h34);
    fp(6'h20);
    sel_i.all_threads_qualifier = 1'b1;
    fp(6'h20);
    check(hits, 3);
    pick(8'h80, 8'h02, 1'b1);
    fp(6'h24);
    fp(6'h2C);
    fp(6'h30);
    // A miss held outstanding for several cycles still counts once.
    fetch_i = 6'h34;
    tick(1);
    fetch_i = 6'h14;
    tick(3);
    fp(6'h00);
    check(hits, 2);
    pick(8'h82, 8'h04, 1'b1);
    fp(6'h06);
    fp(6'h05);
    check(hits, 1);
    pick(8'h82, 8'h02, 1'b1);
    fp(6'h05);
    fp(6'h06);
    check(hits, 1);
  endtask : t_fetch
  task automatic t_refuse;
    pick(8'h80, 8'h01, 1'b0);
    pick(8'h82, 8'h03, 1'b0);
    pick(8'h80, 8'h3A, 1'b0);
    pick(8'h71, 8'h00, 1'b0);
    u_bus_agent_model.send_trans(TR_OTHER);
    sel_i.enable = 1'b0;
    u_bus_agent_model.hold(10'h040);
    tick(2);
    check(supported_o, 0);
    check(hits, 0);
    u_bus_agent_model.hold('0);
  endtask : t_refuse
  task automatic t_reset;
    pick(8'h63, 8'h00, 1'b1);
    u_bus_agent_model.hold(10'h040);
    rst_i = 1'b1;
    tick(2);
    check(incr_o, 0);
    check(supported_o, 0);
    rst_i = 1'b0;
    tick(1);
    check(incr_o, 1);
    tick(2);
    check(incr_o, 1);
    u_bus_agent_model.hold('0);
    tick(2);
  endtask : t_reset
  initial begin
    rst_i   = 1'b1;
    sel_i   = '0;
    fetch_i = '0;
    tick(4);
    check(supported_o, 0);
    rst_i = 1'b0;
    t_levels();
    t_trans();
    t_snoop();
    t_fetch();
    t_refuse();
    t_reset();
    finish_test();
  end
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : tb
